/* verilog/host_port_pkg.sv */
// constants and carrier types for the host port access logic
package host_port_pkg;
    localparam logic [1:0] ACC_CONTROL = 2'h0;
    localparam logic [1:0] ACC_DATA_INC = 2'h1;
    localparam logic [1:0] ACC_ADDRESS = 2'h2;
    localparam logic [1:0] ACC_DATA_FIX = 2'h3;
    localparam int CFG_ENABLE_BIT = 0;
    localparam int CFG_PAGE_BIT = 1;
    localparam int CFG_SEPARATE_BIT = 2;
    localparam int CFG_FULL_BIT = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam int CTRL_CORE_IRQ_BIT = 1;
    localparam int CTRL_HOST_IRQ_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
    localparam int PIN_SYNC_W = 59;

    typedef struct packed {
        logic full_word;
        logic separate_addr_mode;
        logic page_restrict_on;
        logic enable;
    } host_port_config_t;

    typedef struct packed {
        logic cs_n;
        logic [1:0] strobes;
        logic read;
        logic [1:0] access_type;
        logic [3:0] byte_en;
        logic half_sel;
        logic [31:0] data;
        logic [15:0] addr;
    } host_pins_t;

    typedef struct packed {
        logic [1:0] access_type;
        logic read;
        logic [3:0] byte_en;
        logic half_sel;
        logic [15:0] addr;
    } host_cmd_t;
endpackage

/* verilog/host_port_access_logic.sv */
// host port access logic: strobe decode, register window and memory requests
// Function
// - three modes: half-word mux, full-word mux, separate
// - strobe start latches control, end latches data
// - chip select gates the not-ready level
// - access code picks control, address, data
// - half-word mode joins two 16-bit transfers
// - reads drive upper lines unless set as gpio
// - mux modes may pin upper address to page
// - ready held low until internal access completes
// - software can raise the host interrupt
// - control register bit interrupts the core
// - full-word mux: 32 lines, one cycle each
// - separate mode acts like static memory
// - separate mode reaches a 64K-byte page
// - separate mode keeps memory off shared lines
// - boot sets separate mode before memory drives
// - config bit 3 picks full-word mux mode
// - config bit 2 picks separate address mode
// - config bit 1 restricts upper address bits
module host_port_access_logic (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_chip_select_n,
    input wire logic [1:0] host_data_strobes,
    input wire logic host_read,
    input wire logic [1:0] host_access_type,
    input wire logic [3:0] host_byte_enables,
    input wire logic half_word_select,
    input wire logic [31:0] host_data_bus_in,
    output logic [31:0] host_data_bus_out,
    output logic [31:0] host_data_bus_oe,
    input wire logic [15:0] host_address_bus,
    output logic host_ready_out,
    output logic host_irq_out,
    input wire host_port_pkg::host_port_config_t host_port_config,
    input wire logic [7:0] page_addr_top_byte,
    input wire logic [7:0] page_addr_upper_mid_byte,
    input wire logic upper_lines_gpio,
    input wire logic sw_host_irq,
    input wire logic core_irq_clear,
    output logic core_irq_out,
    input wire logic ext_mem_drive_req,
    output logic ext_mem_data_oe,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    typedef enum logic [1:0] {IDLE, MEM, HOLD} state_t;

    host_port_pkg::host_pins_t pins_raw;
    host_port_pkg::host_pins_t pins_meta;
    host_port_pkg::host_pins_t pins;
    host_port_pkg::host_cmd_t cmd;
    state_t state;
    logic strobe_now;
    logic strobe_prev;
    logic strobe_old;
    logic strobe_fall;
    logic strobe_rise;
    logic [31:0] port_control_reg;
    logic [31:0] port_address_reg;
    logic [31:0] port_data_window;
    logic [15:0] low_half;
    logic [31:0] eff_addr;
    logic half_mode;
    logic is_data;
    logic busy;

    function automatic logic [31:0] merge_half(input logic [31:0] cur, input logic [15:0] val, input logic hi);
        merge_half = hi ? {val, cur[15:0]} : {cur[31:16], val};
    endfunction

    assign pins_raw = '{host_chip_select_n, host_data_strobes, host_read, host_access_type,
                        host_byte_enables, half_word_select, host_data_bus_in, host_address_bus};

    // async host pins pass two flops before use, except chip select gating ready
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pins_meta <= '{cs_n: 1'b1, default: '0};
            pins <= '{cs_n: 1'b1, default: '0};
        end
        else
        begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
        end
    end

    assign strobe_now = ~pins.cs_n & (pins.strobes[1] ^ pins.strobes[0]) & host_port_config.enable;
    assign strobe_fall = strobe_now & ~strobe_prev;
    assign strobe_rise = ~strobe_now & strobe_prev;
    // full-word select only without separate mode
    assign half_mode = ~host_port_config.separate_addr_mode & ~host_port_config.full_word;
    assign is_data = cmd.access_type[0];

    // separate mode: software page plus host pins
    always_comb
    begin
        if (host_port_config.separate_addr_mode)
            eff_addr = {page_addr_top_byte, page_addr_upper_mid_byte, cmd.addr};
        else if (host_port_config.page_restrict_on)
            eff_addr = {page_addr_top_byte, page_addr_upper_mid_byte, port_address_reg[15:0]};
        else
            eff_addr = port_address_reg;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            strobe_prev <= 1'b0;
            strobe_old <= 1'b0;
        end
        else
        begin
            strobe_prev <= strobe_now;
            strobe_old <= strobe_prev;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cmd <= '0;
        else if (strobe_fall)
            cmd <= '{pins.access_type, pins.read, pins.byte_en, pins.half_sel, pins.addr};
    end

    // sequencer: reads start at strobe start, writes at strobe end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state <= IDLE;
        else
        begin
            case (state)
                IDLE:
                begin
                    // read fetches the word on the first half only
                    if (strobe_fall && pins.read && pins.access_type[0] && !(half_mode && pins.half_sel))
                        state <= MEM;
                    // write issued once the second half arrives
                    else if (strobe_rise && !cmd.read && is_data && !(half_mode && !cmd.half_sel))
                        state <= MEM;
                end
                MEM:
                    if (mem_ack)
                        state <= strobe_now ? HOLD : IDLE;
                HOLD:
                    if (!strobe_now)
                        state <= IDLE;
                default:
                    state <= IDLE;
            endcase
        end
    end

    assign busy = (state == MEM);
    assign mem_req = busy;
    assign mem_we = ~cmd.read;
    assign mem_addr = eff_addr;
    assign mem_wdata = port_data_window;
    assign mem_be = half_mode ? 4'hF : cmd.byte_en;

    assign host_ready_out = host_chip_select_n | ~busy;

    // write data latched at strobe end
    // low half kept until the high half arrives
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_data_window <= '0;
            low_half <= '0;
        end
        else if (state == MEM && mem_ack && cmd.read)
            port_data_window <= mem_rdata;
        else if (strobe_rise && !cmd.read && is_data)
        begin
            if (!half_mode)
                port_data_window <= pins.data;
            else if (!cmd.half_sel)
                low_half <= pins.data[15:0];
            else
                port_data_window <= {pins.data[15:0], low_half};
        end
    end

    // full-word mode writes in one cycle
    // autoincrement steps one word after each ACC_DATA_INC access outside separate mode
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            port_address_reg <= host_port_pkg::ADDR_RESET;
        else if (strobe_rise && !cmd.read && cmd.access_type == host_port_pkg::ACC_ADDRESS)
        begin
            if (half_mode)
                port_address_reg <= merge_half(port_address_reg, pins.data[15:0], cmd.half_sel);
            else
                port_address_reg <= pins.data;
        end
        // writes step only once memory has taken the old address
        else if (cmd.access_type == host_port_pkg::ACC_DATA_INC && !host_port_config.separate_addr_mode
                 && ((strobe_rise && cmd.read && !(half_mode && !cmd.half_sel))
                     || (state == MEM && mem_ack && !cmd.read)))
            port_address_reg <= port_address_reg + host_port_pkg::ADDR_STEP;
    end

    // host sets the core interrupt bit
    // software raises host interrupt, set beats host clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            port_control_reg <= host_port_pkg::CTRL_RESET;
        else
        begin
            // a host set in the same cycle wins over the clear
            if (core_irq_clear)
                port_control_reg[host_port_pkg::CTRL_CORE_IRQ_BIT] <= 1'b0;
            if (strobe_rise && !cmd.read && cmd.access_type == host_port_pkg::ACC_CONTROL
                && !(half_mode && cmd.half_sel))
            begin
                if (pins.data[host_port_pkg::CTRL_CORE_IRQ_BIT])
                    port_control_reg[host_port_pkg::CTRL_CORE_IRQ_BIT] <= 1'b1;
                if (pins.data[host_port_pkg::CTRL_HOST_IRQ_BIT])
                    port_control_reg[host_port_pkg::CTRL_HOST_IRQ_BIT] <= 1'b0;
            end
            if (sw_host_irq)
                port_control_reg[host_port_pkg::CTRL_HOST_IRQ_BIT] <= 1'b1;
        end
    end

    assign core_irq_out = port_control_reg[host_port_pkg::CTRL_CORE_IRQ_BIT];
    assign host_irq_out = port_control_reg[host_port_pkg::CTRL_HOST_IRQ_BIT];

    // read data selected by access code
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            host_data_bus_out <= '0;
        else if (state == MEM && mem_ack && cmd.read)
            host_data_bus_out <= mem_rdata;
        else
        begin
            case (cmd.access_type)
                host_port_pkg::ACC_CONTROL:
                    host_data_bus_out <= port_control_reg;
                host_port_pkg::ACC_ADDRESS:
                    host_data_bus_out <= (half_mode && cmd.half_sel) ? {16'h0000, port_address_reg[31:16]}
                                                                      : port_address_reg;
                default:
                    host_data_bus_out <= (half_mode && cmd.half_sel) ? {16'h0000, port_data_window[31:16]}
                                                                      : port_data_window;
            endcase
        end
    end

    // upper lines driven on reads unless given to gpio
    always_comb
    begin
        host_data_bus_oe = '0;
        // wait until the output register follows the latched command
        if (strobe_now && strobe_old && cmd.read && !busy)
        begin
            host_data_bus_oe[15:0] = 16'hFFFF;
            if (!upper_lines_gpio)
                host_data_bus_oe[31:16] = 16'hFFFF;
        end
    end

    // separate mode keeps the memory interface off the shared lines
    // boot must set separate mode before memory starts driving
    assign ext_mem_data_oe = ext_mem_drive_req & ~host_port_config.separate_addr_mode;

    AST_READY_ONLY_SELECTED: assert property (@(posedge clk) disable iff (rst)
        !host_ready_out |-> !host_chip_select_n) else $error("ready low while deselected");
    AST_READY_TRACKS_BUSY: assert property (@(posedge clk) disable iff (rst)
        (state == MEM && !host_chip_select_n) |-> !host_ready_out) else $error("ready high mid access");
    AST_SHARED_LINES_FREE: assert property (@(posedge clk) disable iff (rst)
        host_port_config.separate_addr_mode |-> !ext_mem_data_oe) else $error("memory drives shared lines");
    AST_PAGE_ADDRESS: assert property (@(posedge clk) disable iff (rst)
        (mem_req && (host_port_config.separate_addr_mode || host_port_config.page_restrict_on))
        |-> mem_addr[31:16] == {page_addr_top_byte, page_addr_upper_mid_byte})
        else $error("page bits wrong");
    AST_AUTOINC_STEP: assert property (@(posedge clk) disable iff (rst)
        (state == MEM && mem_ack && !cmd.read && cmd.access_type == host_port_pkg::ACC_DATA_INC
         && !host_port_config.separate_addr_mode)
        |=> port_address_reg == $past(port_address_reg) + host_port_pkg::ADDR_STEP)
        else $error("autoincrement missing");
    AST_HALF_WRITE_JOIN: assert property (@(posedge clk) disable iff (rst)
        (mem_req && mem_we && half_mode) |-> mem_wdata[15:0] == low_half)
        else $error("half words not joined");
    AST_CORE_IRQ_SET: assert property (@(posedge clk) disable iff (rst)
        (strobe_rise && !cmd.read && cmd.access_type == host_port_pkg::ACC_CONTROL && !half_mode
         && pins.data[host_port_pkg::CTRL_CORE_IRQ_BIT] && !core_irq_clear) |=> core_irq_out)
        else $error("core interrupt not raised");
    AST_HOST_IRQ_SET: assert property (@(posedge clk) disable iff (rst)
        sw_host_irq |=> host_irq_out) else $error("host interrupt not raised");
    AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (rst)
        (!host_port_config.enable && state == IDLE) |=> state == IDLE) else $error("disabled port acted");
    AST_NO_DRIVE_BUSY: assert property (@(posedge clk) disable iff (rst)
        busy |-> host_data_bus_oe == 32'h0000_0000) else $error("bus driven before data ready");

    COV_FULL_READ: cover property (@(posedge clk) disable iff (rst) mem_req && !mem_we && host_port_config.full_word);
    COV_HALF_WRITE: cover property (@(posedge clk) disable iff (rst) mem_req && mem_we && half_mode);
    COV_SEPARATE: cover property (@(posedge clk) disable iff (rst) mem_req && host_port_config.separate_addr_mode);
endmodule // host_port_access_logic

/* test/host_mem_model.sv */
// memory-side responder that answers the port's word requests
module host_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    input wire logic [3:0] wait_cycles,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic [31:0] last_addr,
    output logic [7:0] req_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] store [0:15];
    logic [3:0] wait_cnt;
    // one word per ack; read data is junk outside the ack cycle so stale values never pass
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            req_count <= 8'h00;
            mem_rdata <= 32'hA5A5_A5A5;
        end
        else if (mem_req && !mem_ack && wait_cnt != wait_cycles)
        begin
            wait_cnt <= wait_cnt + 4'h1;
            mem_rdata <= ~mem_rdata;
        end
        else if (mem_req && !mem_ack)
        begin
            mem_ack <= 1'b1;
            wait_cnt <= 4'h0;
            last_addr <= mem_addr;
            req_count <= req_count + 8'h01;
            mem_rdata <= store[mem_addr[5:2]];
            for (int i = 0; i < 4; i++)
                if (mem_we && mem_be[i])
                    store[mem_addr[5:2]][8*i +: 8] <= mem_wdata[8*i +: 8];
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // host_mem_model

/* test/host_port_access_logic_tb_top.sv */
// self-checking bench driving the host pins in all three bus modes
module host_port_access_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, cs_n, read, half, gpio, sw_irq, irq_clr, drive_req, saw_wait;
    logic ready, hirq, cirq, mem_oe, mem_req, mem_we, mem_ack;
    logic [1:0] strobes, acc;
    logic [3:0] be, mem_be, wait_cycles;
    logic [7:0] top, mid, req_count, cnt;
    logic [15:0] haddr;
    logic [31:0] din, dout, oe, oe_seen, mem_addr, mem_wdata, mem_rdata, last_addr, q;
    host_port_pkg::host_port_config_t cfg;
    int err_count, check_count;
    host_port_access_logic dut_u (.clk(clk), .rst(rst), .host_chip_select_n(cs_n), .host_data_strobes(strobes),
        .host_read(read), .host_access_type(acc), .host_byte_enables(be), .half_word_select(half),
        .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe(oe), .host_address_bus(haddr),
        .host_ready_out(ready), .host_irq_out(hirq), .host_port_config(cfg), .page_addr_top_byte(top),
        .page_addr_upper_mid_byte(mid), .upper_lines_gpio(gpio), .sw_host_irq(sw_irq),
        .core_irq_clear(irq_clr), .core_irq_out(cirq), .ext_mem_drive_req(drive_req),
        .ext_mem_data_oe(mem_oe), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    host_mem_model mem_u (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .wait_cycles(wait_cycles), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .last_addr(last_addr), .req_count(req_count));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // pins pass two sync flops, so give at least six clocks before trusting ready
    task automatic hold_until(input logic want_oe);
        for (int n = 0; n < 200; n++)
        begin
            @(posedge clk);
            #1;
            if (ready === 1'b0)
                saw_wait = 1'b1;
            if (want_oe ? oe[0] === 1'b1 : (n >= 6 && ready === 1'b1))
                return;
        end
        err_count++;
        end_of_test();
    endtask
    task automatic xfer(input logic [1:0] t_acc, input logic t_rd, input logic [31:0] t_d,
        input logic [15:0] t_a, input logic t_half, output logic [31:0] t_q);
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        read = t_rd;
        acc = t_acc;
        half = t_half;
        din = t_d;
        haddr = t_a;
        strobes = 2'b01;
        hold_until(t_rd);
        t_q = dout;
        oe_seen = oe;
        @(posedge clk);
        #1;
        strobes = 2'b00;
        hold_until(1'b0);
        cs_n = 1'b1;
    endtask
    // half-word pair: undriven upper lines carry a junk pattern
    task automatic hw(input logic [1:0] t_acc, input logic [31:0] t_d);
        xfer(t_acc, 1'b0, {~t_d[15:0], t_d[15:0]}, 16'h0000, 1'b0, q);
        xfer(t_acc, 1'b0, {~t_d[31:16], t_d[31:16]}, 16'h0000, 1'b1, q);
    endtask
    initial
    begin
        {cs_n, read, half, gpio, sw_irq, irq_clr, drive_req, saw_wait} = 8'h80;
        {strobes, acc, be, wait_cycles, top, mid, haddr, din} = '0;
        be = 4'hF;
        cfg = 4'h0;
        err_count = 0;
        check_count = 0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({28'h0, ready, hirq, cirq, mem_req}, 32'h8);
        chk(oe, 32'h0);
        cfg = 4'h9;
        wait_cycles = 4'h6;
        xfer(host_port_pkg::ACC_ADDRESS, 1'b0, 32'h0000_0010, 16'h0, 1'b0, q);
        xfer(host_port_pkg::ACC_DATA_INC, 1'b0, 32'hA5A5_0001, 16'h0, 1'b0, q);
        chk(last_addr, 32'h0000_0010);
        chk(mem_u.store[4], 32'hA5A5_0001);
        chk({31'h0, saw_wait}, 32'h1);
        xfer(host_port_pkg::ACC_DATA_INC, 1'b0, 32'h5A5A_0002, 16'h0, 1'b0, q);
        chk(last_addr, 32'h0000_0014);
        xfer(host_port_pkg::ACC_ADDRESS, 1'b0, 32'h0000_0010, 16'h0, 1'b0, q);
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b1, 32'h0, 16'h0, 1'b0, q);
        chk(q, 32'hA5A5_0001);
        chk(oe_seen, 32'hFFFF_FFFF);
        gpio = 1'b1;
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b1, 32'h0, 16'h0, 1'b0, q);
        chk(last_addr, 32'h0000_0010);
        chk({16'h0, oe_seen[31:16]}, 32'h0);
        xfer(host_port_pkg::ACC_ADDRESS, 1'b0, 32'h8000_0030, 16'h0, 1'b0, q);
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b0, 32'h1111_2222, 16'h0, 1'b0, q);
        chk(last_addr, 32'h8000_0030);
        cfg = 4'hB;
        top = 8'h12;
        mid = 8'h34;
        xfer(host_port_pkg::ACC_ADDRESS, 1'b0, 32'hFFFF_0020, 16'h0, 1'b0, q);
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b0, 32'h3333_4444, 16'h0, 1'b0, q);
        chk(last_addr, 32'h1234_0020);
        cfg = 4'h1;
        wait_cycles = 4'h0;
        hw(host_port_pkg::ACC_ADDRESS, 32'h0000_0008);
        hw(host_port_pkg::ACC_DATA_INC, 32'hDEAD_BEEF);
        chk(last_addr, 32'h0000_0008);
        chk(mem_u.store[2], 32'hDEAD_BEEF);
        hw(host_port_pkg::ACC_ADDRESS, 32'h0000_0008);
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b1, 32'h0, 16'h0, 1'b0, q);
        chk({16'h0, q[15:0]}, 32'h0000_BEEF);
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b1, 32'h0, 16'h0, 1'b1, q);
        chk({16'h0, q[15:0]}, 32'h0000_DEAD);
        drive_req = 1'b1;
        #1;
        chk({31'h0, mem_oe}, 32'h1);
        cfg = 4'h5;
        #1;
        chk({31'h0, mem_oe}, 32'h0);
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b0, 32'h7777_8888, 16'h0044, 1'b0, q);
        be = 4'h3;
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b0, 32'h0000_1234, 16'h0044, 1'b0, q);
        be = 4'hF;
        chk(last_addr, 32'h1234_0044);
        chk(mem_u.store[1], 32'h7777_1234);
        cfg = 4'h9;
        #1;
        chk({31'h0, mem_oe}, 32'h1);
        xfer(host_port_pkg::ACC_CONTROL, 1'b0, 32'h0000_0002, 16'h0, 1'b0, q);
        chk({31'h0, cirq}, 32'h1);
        irq_clr = 1'b1;
        sw_irq = 1'b1;
        @(posedge clk);
        #1;
        {irq_clr, sw_irq} = 2'b00;
        @(posedge clk);
        #1;
        chk({30'h0, hirq, cirq}, 32'h2);
        xfer(host_port_pkg::ACC_CONTROL, 1'b1, 32'h0, 16'h0, 1'b0, q);
        chk({30'h0, q[2:1]}, 32'h2);
        xfer(host_port_pkg::ACC_CONTROL, 1'b0, 32'h0000_0004, 16'h0, 1'b0, q);
        chk({31'h0, hirq}, 32'h0);
        cfg = 4'h8;
        cnt = req_count;
        xfer(host_port_pkg::ACC_DATA_FIX, 1'b0, 32'h9999_9999, 16'h0, 1'b0, q);
        chk({24'h0, req_count}, {24'h0, cnt});
        end_of_test();
    end
endmodule // host_port_access_logic_tb_top
